/* logic/steer_pkg.sv */
/*
  Shared constants, types and decode functions for the dual-bus word-width steering block.
  Assumes a single core clock domain and 40-bit data registers fed from 64-bit memory buses.
*/
package steer_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned BUS_W = 64;
  localparam int unsigned REG_W = 40;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned NBUS = 2;
  localparam int unsigned NPE = 2;
  localparam int unsigned ZFILL_W = 8;
  localparam int unsigned EXT_W = 40;
  localparam int unsigned EXT_PAD_W = 24;
  localparam int unsigned HALF_W = 32;
  localparam int unsigned NORMAL_W = 32;
  localparam int unsigned SHORT_W = 16;

  // ----------------------------------------------------------------
  // Bus and element numbering
  // ----------------------------------------------------------------
  localparam int unsigned BUS_DATA = 0;
  localparam int unsigned BUS_PROG = 1;
  localparam int unsigned PE_PRI = 0;
  localparam int unsigned PE_SEC = 1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    W_SHORT = 2'b00,
    W_NORMAL = 2'b01,
    W_EXT = 2'b11,
    W_LONG = 2'b10
  } width_e;

  typedef enum logic [1:0] {
    M_SISD = 2'b00,
    M_SIMD = 2'b01,
    M_BCAST = 2'b11
  } mode_e;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic is_wide(input logic [1:0] w);
    is_wide = (w == W_EXT) || (w == W_LONG);
  endfunction

  function automatic logic [IDX_W-1:0] nb_of(input logic [IDX_W-1:0] r);
    nb_of = r ^ {{(IDX_W-1){1'b0}}, 1'b1};
  endfunction

endpackage

/* logic/steer_lane.sv */
/*
  One bus lane: formats load data for the data registers and store data for the bus.
  Assumes register values arrive as 40-bit words with the fraction extension in the low byte.
*/
`timescale 1ns/10ps
module steer_lane
  import steer_pkg::*;
(
  input wire logic [1:0] width,
  input wire logic [steer_pkg::BUS_W-1:0] rdata,
  input wire logic [steer_pkg::REG_W-1:0] src,
  input wire logic [steer_pkg::REG_W-1:0] src_nb,
  output wire logic [steer_pkg::REG_W-1:0] ld_exp,
  output wire logic [steer_pkg::REG_W-1:0] ld_nb,
  output wire logic [steer_pkg::BUS_W-1:0] st_data
);

  // ----------------------------------------------------------------
  // Load formatting
  // ----------------------------------------------------------------
  wire logic [ZFILL_W-1:0] zf = '0;
  wire logic [REG_W-1:0] ld_long_hi = {rdata[BUS_W-1 -: HALF_W], zf};
  wire logic [REG_W-1:0] ld_long_lo = {rdata[HALF_W-1:0], zf};
  wire logic [REG_W-1:0] ld_ext = rdata[BUS_W-1 -: EXT_W];
  wire logic [REG_W-1:0] ld_norm = {rdata[NORMAL_W-1:0], zf};
  wire logic [REG_W-1:0] ld_short = {{(REG_W-SHORT_W-ZFILL_W){1'b0}}, rdata[SHORT_W-1:0], zf};

  assign ld_exp = (width == W_LONG) ? ld_long_hi :
                  (width == W_EXT) ? ld_ext :
                  (width == W_NORMAL) ? ld_norm : ld_short;
  assign ld_nb = ld_long_lo;

  // ----------------------------------------------------------------
  // Store formatting
  // ----------------------------------------------------------------
  wire logic [BUS_W-1:0] st_long = {src[REG_W-1:ZFILL_W], src_nb[REG_W-1:ZFILL_W]};
  wire logic [BUS_W-1:0] st_ext = {src, {EXT_PAD_W{1'b0}}};
  wire logic [BUS_W-1:0] st_norm = {{(BUS_W-NORMAL_W){1'b0}}, src[REG_W-1:ZFILL_W]};
  wire logic [BUS_W-1:0] st_short = {{(BUS_W-SHORT_W){1'b0}}, src[ZFILL_W +: SHORT_W]};

  assign st_data = (width == W_LONG) ? st_long :
                   (width == W_EXT) ? st_ext :
                   (width == W_NORMAL) ? st_norm : st_short;

endmodule

/* logic/dual_steer.sv */
/*
  Steers load and store data between the data-side and program-side memory buses and the
  register files of the primary and secondary elements, one cycle from request to outputs.
  Assumes the register files take the write commands and supply store sources on this clock.
*/
// Function
// - Long word uses the whole 64-bit bus as one lane in one transfer.
// - SIMD dual long: data-side bus to primary, program-side to secondary only.
// - Long word load fills the named register and its neighbour in one element.
// - Long word loads write zeros into the low 8 bits of each register.
// - Each bus in a dual access is formatted by its own width.
// - SISD dual access accepts any width pairing across the buses.
// - Conflicting register targets: only the higher priority access is performed.
// - SIMD dual accepts any mix of extended and long words on the buses.
// - Broadcast load: SISD memory side, SIMD register side, both elements written.
// - Broadcast dual extended or long loads follow their own distinct flow.
// - Extended word rides the upper 40 bus bits, lower 24 bits zero.
`timescale 1ns/10ps
module dual_steer
  import steer_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic [1:0] req_mode,
  input wire logic req_dual,
  input wire logic [steer_pkg::NBUS*2-1:0] req_width,
  input wire logic [steer_pkg::NBUS-1:0] req_load,
  input wire logic [steer_pkg::NBUS*steer_pkg::IDX_W-1:0] req_reg,
  input wire logic [steer_pkg::NBUS-1:0] req_pe,
  input wire logic [steer_pkg::NBUS-1:0] req_indirect,
  input wire logic [steer_pkg::NBUS*steer_pkg::BUS_W-1:0] bus_rdata,
  input wire logic [steer_pkg::NBUS*steer_pkg::REG_W-1:0] src_data,
  input wire logic [steer_pkg::NBUS*steer_pkg::REG_W-1:0] src_nb_data,
  output logic [steer_pkg::NBUS-1:0] bus_wen,
  output logic [steer_pkg::NBUS*steer_pkg::BUS_W-1:0] bus_wdata,
  output logic [steer_pkg::NPE*steer_pkg::NBUS-1:0] rf_we,
  output logic [steer_pkg::NPE*steer_pkg::NBUS-1:0] rf_nb_we,
  output logic [steer_pkg::NPE*steer_pkg::NBUS*steer_pkg::IDX_W-1:0] rf_idx,
  output logic [steer_pkg::NPE*steer_pkg::NBUS*steer_pkg::IDX_W-1:0] rf_nb_idx,
  output logic [steer_pkg::NPE*steer_pkg::NBUS*steer_pkg::REG_W-1:0] rf_wdata,
  output logic [steer_pkg::NPE*steer_pkg::NBUS*steer_pkg::REG_W-1:0] rf_nb_wdata,
  output logic conflict_drop,
  output logic illegal_req
);

  localparam int unsigned NK = NPE * NBUS;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic is_sisd = (req_mode == M_SISD);
  wire logic is_simd = (req_mode == M_SIMD);
  wire logic is_bcast = (req_mode == M_BCAST);
  wire logic [1:0] w0 = req_width[1:0];
  wire logic [1:0] w1 = req_width[3:2];
  wire logic both_wide = is_wide(w0) && is_wide(w1);
  wire logic simd_wide = is_simd && req_dual && both_wide;
  wire logic bc_wide = is_bcast && req_dual && (is_wide(w0) || is_wide(w1));
  wire logic pair_bad = is_simd && req_dual && (is_wide(w0) != is_wide(w1));
  wire logic direct_bad = req_dual && !(&req_indirect);
  wire logic [NBUS-1:0] bus_on = {req_valid && req_dual, req_valid};

  logic [NBUS*REG_W-1:0] ld_exp_w;
  logic [NBUS*REG_W-1:0] ld_nb_w;
  logic [NBUS*BUS_W-1:0] st_w;
  logic [NK-1:0] hit;
  logic [NK-1:0] raw_k;
  logic [NK-1:0] nb_hit;
  logic [NPE-1:0] clash;

  // ----------------------------------------------------------------
  // Lane formatting and element routing
  // ----------------------------------------------------------------
  genvar b, p;
  generate
    for (b = 0; b < NBUS; b++) begin : g_bus
      steer_lane u_lane (
        .width(req_width[b*2 +: 2]),
        .rdata(bus_rdata[b*BUS_W +: BUS_W]),
        .src(src_data[b*REG_W +: REG_W]),
        .src_nb(src_nb_data[b*REG_W +: REG_W]),
        .ld_exp(ld_exp_w[b*REG_W +: REG_W]),
        .ld_nb(ld_nb_w[b*REG_W +: REG_W]),
        .st_data(st_w[b*BUS_W +: BUS_W])
      );
      for (p = 0; p < NPE; p++) begin : g_pe
        wire logic named = (p == PE_PRI) ? !req_pe[b] : req_pe[b];
        wire logic route = is_bcast ? 1'b1 :
                           simd_wide ? (b == p) : named;
        wire logic is_long = (req_width[b*2 +: 2] == W_LONG);
        assign raw_k[p*NBUS+b] = bus_on[b] && req_load[b] && route;
        // The program-side bus loses when both loads land on one register.
        assign hit[p*NBUS+b] = raw_k[p*NBUS+b] && !((b == BUS_PROG) && clash[p]);
        assign nb_hit[p*NBUS+b] = hit[p*NBUS+b] && is_long && !bc_wide;
      end
    end
    for (p = 0; p < NPE; p++) begin : g_clash
      wire logic [IDX_W-1:0] r0 = req_reg[0 +: IDX_W];
      wire logic [IDX_W-1:0] r1 = req_reg[IDX_W +: IDX_W];
      wire logic l0 = (w0 == W_LONG) && !bc_wide;
      wire logic l1 = (w1 == W_LONG) && !bc_wide;
      wire logic both = raw_k[p*NBUS] && raw_k[p*NBUS+1];
      wire logic ovl = (r0 == r1) || (l0 && nb_of(r0) == r1) ||
                       (l1 && nb_of(r1) == r0) || (l0 && l1 && nb_of(r0) == nb_of(r1));
      assign clash[p] = both && ovl;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  logic [NK*IDX_W-1:0] idx_d;
  logic [NK*IDX_W-1:0] nb_idx_d;
  logic [NK*REG_W-1:0] wdata_d;
  logic [NK*REG_W-1:0] nb_wdata_d;
  generate
    for (p = 0; p < NPE; p++) begin : g_out_pe
      for (b = 0; b < NBUS; b++) begin : g_out_bus
        assign idx_d[(p*NBUS+b)*IDX_W +: IDX_W] = req_reg[b*IDX_W +: IDX_W];
        assign nb_idx_d[(p*NBUS+b)*IDX_W +: IDX_W] = nb_of(req_reg[b*IDX_W +: IDX_W]);
        assign wdata_d[(p*NBUS+b)*REG_W +: REG_W] = ld_exp_w[b*REG_W +: REG_W];
        assign nb_wdata_d[(p*NBUS+b)*REG_W +: REG_W] = ld_nb_w[b*REG_W +: REG_W];
      end
    end
  endgenerate

  wire logic [NBUS-1:0] wen_d = bus_on & ~req_load;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_wen <= '0;
      bus_wdata <= '0;
      rf_we <= '0;
      rf_nb_we <= '0;
      rf_idx <= '0;
      rf_nb_idx <= '0;
      rf_wdata <= '0;
      rf_nb_wdata <= '0;
      conflict_drop <= 1'b0;
      illegal_req <= 1'b0;
    end else if (ce) begin
      bus_wen <= wen_d;
      bus_wdata <= st_w;
      rf_we <= hit;
      rf_nb_we <= nb_hit;
      rf_idx <= idx_d;
      rf_nb_idx <= nb_idx_d;
      rf_wdata <= wdata_d;
      rf_nb_wdata <= nb_wdata_d;
      conflict_drop <= |clash;
      illegal_req <= req_valid && (pair_bad || direct_bad);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire logic [HALF_W-1:0] rd0_hi = bus_rdata[BUS_W-1 -: HALF_W];
  wire logic [HALF_W-1:0] rd0_lo = bus_rdata[HALF_W-1:0];
  wire logic [EXT_W-1:0] rd1_ext = bus_rdata[2*BUS_W-1 -: EXT_W];
  wire logic [HALF_W-1:0] src0_top = src_data[REG_W-1:ZFILL_W];
  wire logic [HALF_W-1:0] srcnb0_top = src_nb_data[REG_W-1:ZFILL_W];
  wire logic [IDX_W-1:0] reg0 = req_reg[IDX_W-1:0];
  wire logic long0_ld = req_valid && req_load[0] && (w0 == W_LONG);

  property p_long_store;
    ce && req_valid && !req_load[0] && (w0 == W_LONG) |=>
      bus_wen[0] && bus_wdata[BUS_W-1:0] == {$past(src0_top), $past(srcnb0_top)};
  endproperty
  a_long_store: assert property (p_long_store) else $error("long store lane wrong");

  property p_simd_route;
    ce && req_valid && req_dual && is_simd && both_wide && (&req_load) |=>
      rf_we == 4'h9;
  endproperty
  a_simd_route: assert property (p_simd_route) else $error("simd wide routing wrong");

  property p_long_nb;
    ce && long0_ld && !req_dual && is_sisd && !req_pe[0] |=>
      rf_we[0] && rf_nb_we[0] && rf_idx[IDX_W-1:0] == $past(reg0) &&
      rf_nb_idx[IDX_W-1:0] == ($past(reg0) ^ 4'h1);
  endproperty
  a_long_nb: assert property (p_long_nb) else $error("neighbour not filled");

  property p_zero_fill;
    ce && long0_ld && !req_dual && is_sisd && !req_pe[0] |=>
      rf_wdata[REG_W-1:0] == {$past(rd0_hi), 8'h00} &&
      rf_nb_wdata[REG_W-1:0] == {$past(rd0_lo), 8'h00};
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("low byte not zero");

  property p_ext_bus1;
    ce && req_valid && req_dual && is_simd && (&req_load) && (w1 == W_EXT) && is_wide(w0) |=>
      rf_wdata[3*REG_W +: REG_W] == $past(rd1_ext);
  endproperty
  a_ext_bus1: assert property (p_ext_bus1) else $error("ext lane data wrong");

  property p_conflict;
    ce && |clash |=> conflict_drop && !(rf_we[1] && rf_we[0] && rf_idx[3:0] == rf_idx[7:4]);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not resolved");

  property p_bcast_both;
    ce && req_valid && is_bcast && req_load[0] |=> rf_we[0] && rf_we[2];
  endproperty
  a_bcast_both: assert property (p_bcast_both) else $error("broadcast missed element");

  property p_bcast_wide;
    ce && req_valid && is_bcast && req_dual && (w0 == W_LONG) |=> rf_nb_we == 4'h0;
  endproperty
  a_bcast_wide: assert property (p_bcast_wide) else $error("broadcast wide flow wrong");

  property p_short_store;
    ce && req_valid && !req_load[0] && (w0 == W_SHORT) |=>
      bus_wdata[BUS_W-1:SHORT_W] == '0;
  endproperty
  a_short_store: assert property (p_short_store) else $error("short store not low");

  property p_illegal;
    ce && req_valid && (pair_bad || direct_bad) |=> illegal_req;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal request not flagged");

  c_sisd_mixed: cover property (ce && req_valid && req_dual && is_sisd && w0 != w1);
  c_simd_wide: cover property (ce && simd_wide && (&req_load));
  c_bcast_dual: cover property (ce && req_valid && is_bcast && req_dual);
  c_conflict: cover property (ce && |clash);

endmodule

/* testbench/mem_model.sv */
/*
  Behavioural model of the two internal memory blocks behind the data buses.
  Assumes the steering block drives store strobes on the core clock; preload comes from the bench.
*/
`timescale 1ns/10ps
module mem_model (
  input wire logic clk,
  input wire logic [1:0] pl_we,
  input wire logic [127:0] pl_data,
  input wire logic [1:0] bus_wen,
  input wire logic [127:0] bus_wdata,
  output logic [127:0] bus_rdata
);
  logic [127:0] mem_q;
  // --------------------------------------------------------------
  // One 64-bit word per block, read whole and written whole.
  // --------------------------------------------------------------
  assign bus_rdata = mem_q;
  always_ff @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (pl_we[b]) begin
        mem_q[b*64 +: 64] <= pl_data[b*64 +: 64];
      end else if (bus_wen[b]) begin
        mem_q[b*64 +: 64] <= bus_wdata[b*64 +: 64];
      end
    end
  end
endmodule

/* testbench/dual_bus_word_width_steering_tb.sv */
/*
  Self-checking bench for the dual-bus steering block.
  Assumes one core clock, latency one as handed over, and the memory model as far side.
*/
`timescale 1ns/10ps
module dual_bus_word_width_steering_tb;
  import steer_pkg::*;
  logic clk = 0, srst = 1, ce = 1, req_valid = 0, req_dual = 0;
  logic [1:0] req_mode = 0, req_load = 0, req_pe = 0, req_indirect = 0, bus_wen, pl_we = 0;
  logic [3:0] req_width = 0, rf_we, rf_nb_we;
  logic [7:0] req_reg = 0;
  logic [127:0] bus_rdata, bus_wdata, pl_data = 0;
  logic [79:0] src_data = 0, src_nb_data = 0;
  logic [15:0] rf_idx, rf_nb_idx;
  logic [159:0] rf_wdata, rf_nb_wdata;
  logic conflict_drop, illegal_req;
  int mismatches = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  dual_steer dut_u (.clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid),
    .req_mode(req_mode), .req_dual(req_dual), .req_width(req_width), .req_load(req_load),
    .req_reg(req_reg), .req_pe(req_pe), .req_indirect(req_indirect), .bus_rdata(bus_rdata),
    .src_data(src_data), .src_nb_data(src_nb_data), .bus_wen(bus_wen), .bus_wdata(bus_wdata),
    .rf_we(rf_we), .rf_nb_we(rf_nb_we), .rf_idx(rf_idx), .rf_nb_idx(rf_nb_idx),
    .rf_wdata(rf_wdata), .rf_nb_wdata(rf_nb_wdata), .conflict_drop(conflict_drop),
    .illegal_req(illegal_req));
  mem_model mem_u (.clk(clk), .pl_we(pl_we), .pl_data(pl_data), .bus_wen(bus_wen),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  // --------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pre(input logic [127:0] d);
    @(negedge clk);
    pl_we = 2'b11;
    pl_data = d;
    @(negedge clk);
    pl_we = 2'b00;
  endtask
  task automatic go(input logic [1:0] m, input logic d, input logic [3:0] w,
    input logic [1:0] l, input logic [7:0] r, input logic [1:0] i);
    @(negedge clk);
    req_mode = m;
    req_dual = d;
    req_width = w;
    req_load = l;
    req_reg = r;
    req_pe = 2'b00;
    req_indirect = i;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
  endtask
  // --------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------
  task automatic t_long();
    pre({64'h0, 64'h1122334455667788});
    go(M_SISD, 0, {2'b00, W_LONG}, 2'b01, 8'h04, 2'b11);
    chk("we", 4'b0001, rf_we);
    chk("nb_we", 4'b0001, rf_nb_we);
    chk("nb_idx", 4'h5, rf_nb_idx[3:0]);
    chk("wdata", 40'h1122334400, rf_wdata[39:0]);
    chk("nb_wdata", 40'h5566778800, rf_nb_wdata[39:0]);
  endtask
  task automatic t_simd_long();
    pre({64'haaaabbbbccccdddd, 64'h1122334455667788});
    go(M_SIMD, 1, {W_LONG, W_EXT}, 2'b11, 8'h26, 2'b11);
    chk("we", 4'b1001, rf_we);
    chk("nb_we", 4'b1000, rf_nb_we);
    chk("idx3", 4'h2, rf_idx[15:12]);
    chk("wd3", 40'haaaabbbb00, rf_wdata[159:120]);
    chk("wd0", 40'h1122334455, rf_wdata[39:0]);
    chk("illegal", 1'b0, illegal_req);
  endtask
  task automatic t_mixed();
    pre({64'hffffffffffffabcd, 64'h1122334455667788});
    go(M_SISD, 1, {W_SHORT, W_LONG}, 2'b11, 8'h84, 2'b11);
    chk("we", 4'b0011, rf_we);
    chk("wd1", 40'h0000abcd00, rf_wdata[79:40]);
    chk("wd0", 40'h1122334400, rf_wdata[39:0]);
  endtask
  task automatic t_conflict();
    go(M_SISD, 1, {W_LONG, W_LONG}, 2'b11, 8'h54, 2'b11);
    chk("drop", 1'b1, conflict_drop);
    chk("we", 4'b0001, rf_we);
  endtask
  task automatic t_illegal();
    go(M_SIMD, 1, {W_EXT, W_SHORT}, 2'b11, 8'h31, 2'b11);
    chk("illegal_pair", 1'b1, illegal_req);
    go(M_SISD, 1, {W_NORMAL, W_NORMAL}, 2'b11, 8'h31, 2'b01);
    chk("illegal_direct", 1'b1, illegal_req);
    go(M_SIMD, 1, {W_NORMAL, W_SHORT}, 2'b11, 8'h31, 2'b11);
    chk("legal_pair", 1'b0, illegal_req);
  endtask
  task automatic t_ext_store();
    src_data = {40'h0, 40'h123456789a};
    go(M_SISD, 0, {2'b00, W_EXT}, 2'b00, 8'h00, 2'b11);
    chk("wen", 2'b01, bus_wen);
    chk("wdata", 64'h123456789a000000, bus_wdata[63:0]);
    @(negedge clk);
    chk("mem", 64'h123456789a000000, bus_rdata[63:0]);
  endtask
  task automatic t_bcast();
    pre({64'h0, 64'h00000000deadbeef});
    go(M_BCAST, 0, {2'b00, W_NORMAL}, 2'b01, 8'h07, 2'b11);
    chk("we", 4'b0101, rf_we);
    chk("wd2", 40'hdeadbeef00, rf_wdata[119:80]);
    chk("idx2", 4'h7, rf_idx[11:8]);
    go(M_BCAST, 1, {W_LONG, W_LONG}, 2'b11, 8'h62, 2'b11);
    chk("we_l", 4'b1111, rf_we);
    chk("nb_we_l", 4'b0000, rf_nb_we);
  endtask
  task automatic t_hold();
    go(M_BCAST, 0, {2'b00, W_NORMAL}, 2'b01, 8'h03, 2'b11);
    chk("hold_we0", 4'b0101, rf_we);
    ce = 0;
    go(M_SISD, 0, {2'b00, W_SHORT}, 2'b00, 8'h01, 2'b11);
    chk("hold_we", 4'b0101, rf_we);
    chk("hold_idx", 4'h3, rf_idx[3:0]);
    chk("hold_wen", 2'b00, bus_wen);
    srst = 1;
    @(negedge clk);
    srst = 0;
    ce = 1;
    chk("rst_mid_we", 4'b0000, rf_we);
    chk("rst_mid_idx", 16'h0000, rf_idx);
  endtask
  // --------------------------------------------------------------
  // Main sequence and hang guard.
  // --------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    chk("rst_we", 4'b0000, rf_we);
    chk("rst_wen", 2'b00, bus_wen);
    t_long();
    t_simd_long();
    t_mixed();
    t_conflict();
    t_illegal();
    t_ext_store();
    t_bcast();
    t_hold();
    final_report();
  end
endmodule
